// ### verilog/rxdc_cfg.svh
`ifndef RXDC_CFG_SVH
`define RXDC_CFG_SVH

// Register offsets
`define RXDC_ADDR_W          8
`define RXDC_OFS_RX_CFG2     8'h0b
`define RXDC_OFS_RX_CFG3     8'h0c
`define RXDC_OFS_RX_CFG4     8'h0d
`define RXDC_OFS_STATUS      8'h40
`define RXDC_OFS_ADC_OUT     8'h41

// Receiver configuration two fields
`define RXDC_LP_HI_BIT       5
`define RXDC_LP_LO_BIT       3
`define RXDC_ZERO_HI_BIT     2
`define RXDC_ZERO_LO_BIT     0

// Receiver configuration three fields
`define RXDC_CLIP_BIT        1
`define RXDC_GAIN_CUT_BIT    0

// Status fields
`define RXDC_ST_RX_ON_BIT    0
`define RXDC_ST_MASK_BIT     1
`define RXDC_ST_SQ_BIT       2
`define RXDC_ST_BUSY_BIT     3

// Reset values
`define RXDC_RST_RX_CFG2     8'h00
`define RXDC_RST_RX_CFG3     8'h00
`define RXDC_RST_RX_CFG4     8'h00

// Timing
`define RXDC_CLK_MHZ         25
`define RXDC_MEAS_AMP_US     25
`define RXDC_SQUELCH_US      500
`define RXDC_MEAS_AMP_CYC    (`RXDC_MEAS_AMP_US * `RXDC_CLK_MHZ)
`define RXDC_SQUELCH_CYC     (`RXDC_SQUELCH_US * `RXDC_CLK_MHZ)

`endif

// ### verilog/rxdc_pkg.sv
package rxdc_pkg;

  typedef enum logic [2:0]
  {
    RXDC_CMD_NONE       = 3'h0,
    RXDC_CMD_MASK_RX    = 3'h1,
    RXDC_CMD_UNMASK_RX  = 3'h2,
    RXDC_CMD_MEAS_AMP   = 3'h3,
    RXDC_CMD_SQUELCH    = 3'h4,
    RXDC_CMD_RST_GAIN   = 3'h5
  } rxdc_cmd_t;

  typedef enum logic [1:0]
  {
    RXDC_ST_IDLE    = 2'b00,
    RXDC_ST_MEAS    = 2'b01,
    RXDC_ST_SQUELCH = 2'b10
  } rxdc_state_t;

endpackage

// ### verilog/rxdc_gate.sv
`timescale 1ns/1ps
`default_nettype none

// Combines command mask and timer mask into the receive gate
module rxdc_gate
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Controls
  input  wire logic rx_en,
  input  wire logic mask_cmd,
  input  wire logic unmask_cmd,
  input  wire logic timer_mask,
  // Results
  output logic      mask_q,
  output logic      rx_on_q
);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mask_q <= 1'b0;
    else if (unmask_cmd)
      mask_q <= 1'b0;
    else if (mask_cmd)
      mask_q <= 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_on_q <= 1'b0;
    else if (unmask_cmd)
      rx_on_q <= rx_en;
    else if (mask_cmd)
      rx_on_q <= 1'b0;
    else
      rx_on_q <= rx_en & ~mask_q & ~timer_mask;
  end

endmodule

`default_nettype wire

// ### verilog/rxdc_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Down counter with done pulse and abort
module rxdc_timer
#(
  parameter int W = 14
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  input  wire logic         abort,
  // Status
  output logic              busy_q,
  output logic              done_q
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (abort)
      begin
        busy_q <= 1'b0;
        cnt_q  <= '0;
      end
      else if (start)
      begin
        busy_q <= 1'b1;
        cnt_q  <= load;
      end
      else if (busy_q)
      begin
        if (cnt_q <= W'(1))
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          cnt_q  <= '0;
        end
        else
          cnt_q <= cnt_q - W'(1);
      end
    end
  end

endmodule

`default_nettype wire

// ### verilog/rxdc_unit.sv
// How it works
// [R1] Mask command drops the receive gate, stopping RSSI, AGC and framing.
// [R2] Effective mask is command mask OR mask timer state.
// [R3] Unmask command raises the receive gate and re-enables framing.
// [R4] Unmask during a running mask timer enables reception and resets the timer.
// [R5] Mask and unmask are accepted only when receiver enable is set.
// [R6] Mask and unmask allow chaining and raise no termination event.
// [R7] Measure amplitude enables transmitter, detector, ADC absolute mode, stores result.
// [R8] Measure amplitude finishes within 25 us.
// [R9] Measure amplitude needs oscillator enable and a stable crystal.
// [R10] Measure amplitude blocks chaining and raises a termination event.
// [R11] Squelch finishes within 500 us.
// [R12] Squelch is accepted only with transmitter and receiver operating.
// [R13] Accepted squelch runs only while the receive gate is low; the code checks the gate only when squelch is accepted.
// [R14] Squelch raises no termination event and blocks chaining.
// [R15] Reset gain aborts squelch, clears setting, loads manual gain reduction.
// [R16] Reset gain reinitialises AGC, squelch, RSSI; needs oscillator; chains; no event.
// [R17] Config three bit 1 enables clipping of first and second stage.
// [R18] Config three bit 0 forces gain reduction in second and third stage.
// [R19] Config two bits 5 to 3 select the receive low-pass filter.
// [R20] Config two bits 2 to 0 select first and third stage zeros.
// [R21] A command whose conditions fail is dropped with no effect.
// [R22] Command mask stays set until an unmask command clears it.
//
// Added by the designer: the plain strobed port.
`include "rxdc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rxdc_unit
#(
  parameter int MEAS_CYC = `RXDC_MEAS_AMP_CYC,
  parameter int SQ_CYC   = `RXDC_SQUELCH_CYC
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Command port
  input  wire logic [2:0] cmd_code,
  input  wire logic       cmd_valid,
  // Device state
  input  wire logic       osc_en,
  input  wire logic       osc_stable,
  input  wire logic       rx_en,
  input  wire logic       tx_en,
  input  wire logic       mask_timer_run,
  input  wire logic [7:0] adc_data,
  input  wire logic       adc_valid,
  // Command results
  output logic            cmd_done_irq,
  output logic            chain_ok,
  output logic            mask_timer_clr,
  output logic            rx_on,
  output logic            framing_en,
  output logic            tx_force,
  output logic            amp_det_en,
  output logic            adc_abs_sel,
  output logic            squelch_active,
  output logic            gain_init,
  output logic      [7:0] gain_red_load,
  // Receiver settings
  output logic      [2:0] lowpass_sel,
  output logic      [2:0] zero_sel,
  output logic            stage_clip_en,
  output logic            active_p2p_gain_cut
);

  // ********************
  // Command decode
  // ********************
  function automatic logic is_cmd(input logic [2:0] code, input rxdc_pkg::rxdc_cmd_t c);
    is_cmd = cmd_valid && (code == c);
  endfunction

  logic osc_ok;
  logic busy;
  logic mask_go;
  logic unmask_go;
  logic meas_go;
  logic sq_go;
  logic rg_go;
  logic mask_q;
  logic rx_on_g;
  logic meas_busy;
  logic meas_done;
  logic sq_busy;
  logic sq_done;
  rxdc_pkg::rxdc_state_t state_q;
  logic tmr_ovr_q;
  logic tmr_mask_eff;
  logic meas_end;
  logic sq_end;

  assign osc_ok    = osc_en & osc_stable;                              // R9
  assign busy      = (state_q != rxdc_pkg::RXDC_ST_IDLE);
  assign mask_go   = is_cmd(cmd_code, rxdc_pkg::RXDC_CMD_MASK_RX) & rx_en;    // R5
  assign unmask_go = is_cmd(cmd_code, rxdc_pkg::RXDC_CMD_UNMASK_RX) & rx_en;  // R5
  assign meas_go   = is_cmd(cmd_code, rxdc_pkg::RXDC_CMD_MEAS_AMP) & osc_ok & ~busy; // R9
  // R12 R13 R21
  assign sq_go     = is_cmd(cmd_code, rxdc_pkg::RXDC_CMD_SQUELCH) & tx_en & rx_en
                     & ~rx_on_g & ~busy;
  assign rg_go     = is_cmd(cmd_code, rxdc_pkg::RXDC_CMD_RST_GAIN) & osc_ok; // R16
  assign meas_end  = (state_q == rxdc_pkg::RXDC_ST_MEAS) & (meas_done | adc_valid); // R8
  assign sq_end    = (state_q == rxdc_pkg::RXDC_ST_SQUELCH) & (sq_done | rg_go); // R11 R15
  assign tmr_mask_eff = mask_timer_run & ~tmr_ovr_q; // R2 R4

  // ********************
  // Receive gate
  // ********************
  rxdc_gate u_gate
  (
    .clk        (clk),
    .rst        (rst),
    .rx_en      (rx_en),
    .mask_cmd   (mask_go),
    .unmask_cmd (unmask_go),
    .timer_mask (tmr_mask_eff),
    .mask_q     (mask_q),
    .rx_on_q    (rx_on_g)
  );

  assign rx_on = rx_on_g;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      framing_en     <= 1'b0;
      mask_timer_clr <= 1'b0;
    end
    else
    begin
      framing_en     <= unmask_go ? 1'b1 : (mask_go ? 1'b0 : ~mask_q & ~tmr_mask_eff); // R1 R2 R3
      mask_timer_clr <= unmask_go & mask_timer_run; // R4
    end
  end

  // Unmask overrides a running mask timer until it stops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tmr_ovr_q <= 1'b0;
    else if (!mask_timer_run)
      tmr_ovr_q <= 1'b0;
    else if (unmask_go)
      tmr_ovr_q <= 1'b1; // R4
  end

  // ********************
  // Timed commands
  // ********************
  // Loaded one short so the end lands exactly on the limit
  rxdc_timer #(.W(16)) u_meas
  (
    .clk    (clk),
    .rst    (rst),
    .start  (meas_go),
    .load   (16'(MEAS_CYC - 1)),
    .abort  (meas_end),
    .busy_q (meas_busy),
    .done_q (meas_done)
  );

  rxdc_timer #(.W(16)) u_sq
  (
    .clk    (clk),
    .rst    (rst),
    .start  (sq_go),
    .load   (16'(SQ_CYC - 1)),
    .abort  (rg_go),
    .busy_q (sq_busy),
    .done_q (sq_done)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_q <= rxdc_pkg::RXDC_ST_IDLE;
    else
    begin
      case (state_q)
        rxdc_pkg::RXDC_ST_IDLE:
          if (meas_go)
            state_q <= rxdc_pkg::RXDC_ST_MEAS;
          else if (sq_go)
            state_q <= rxdc_pkg::RXDC_ST_SQUELCH;
        rxdc_pkg::RXDC_ST_MEAS:
          if (meas_done || adc_valid)
            state_q <= rxdc_pkg::RXDC_ST_IDLE; // R8
        rxdc_pkg::RXDC_ST_SQUELCH:
          if (sq_done || rg_go)
            state_q <= rxdc_pkg::RXDC_ST_IDLE; // R11 R15
        default:
          state_q <= rxdc_pkg::RXDC_ST_IDLE;
      endcase
    end
  end

  logic [7:0] adc_out_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_force       <= 1'b0;
      amp_det_en     <= 1'b0;
      adc_abs_sel    <= 1'b0;
      adc_out_q      <= 8'h00;
      cmd_done_irq   <= 1'b0;
      squelch_active <= 1'b0;
    end
    else
    begin
      tx_force       <= meas_go | (state_q == rxdc_pkg::RXDC_ST_MEAS && !meas_done && !adc_valid); // R7
      amp_det_en     <= meas_go | (state_q == rxdc_pkg::RXDC_ST_MEAS && !meas_done && !adc_valid); // R7
      adc_abs_sel    <= meas_go | (state_q == rxdc_pkg::RXDC_ST_MEAS && !meas_done && !adc_valid); // R7
      if (state_q == rxdc_pkg::RXDC_ST_MEAS && adc_valid)
        adc_out_q <= adc_data; // R7
      cmd_done_irq   <= state_q == rxdc_pkg::RXDC_ST_MEAS && (meas_done || adc_valid); // R10 R6 R14
      squelch_active <= sq_go | (sq_busy & ~sq_done & ~rg_go); // R13 R15
    end
  end

  // Chaining allowed unless a non-chaining command runs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      chain_ok <= 1'b1;
    else
      chain_ok <= ~(meas_go | sq_go | (busy & ~meas_end & ~sq_end)); // R6 R10 R14
  end

  // ********************
  // Registers
  // ********************
  logic [7:0] cfg2_q;
  logic [7:0] cfg3_q;
  logic [7:0] cfg4_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg2_q <= `RXDC_RST_RX_CFG2;
      cfg3_q <= `RXDC_RST_RX_CFG3;
      cfg4_q <= `RXDC_RST_RX_CFG4;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `RXDC_OFS_RX_CFG2)
        cfg2_q <= reg_wdata;
      if (reg_addr == `RXDC_OFS_RX_CFG3)
        cfg3_q <= {6'h00, reg_wdata[1:0]};
      if (reg_addr == `RXDC_OFS_RX_CFG4)
        cfg4_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lowpass_sel         <= 3'h0;
      zero_sel            <= 3'h0;
      stage_clip_en       <= 1'b0;
      active_p2p_gain_cut <= 1'b0;
      gain_init           <= 1'b0;
      gain_red_load       <= 8'h00;
    end
    else
    begin
      lowpass_sel         <= cfg2_q[`RXDC_LP_HI_BIT:`RXDC_LP_LO_BIT];     // R19
      zero_sel            <= cfg2_q[`RXDC_ZERO_HI_BIT:`RXDC_ZERO_LO_BIT]; // R20
      stage_clip_en       <= cfg3_q[`RXDC_CLIP_BIT];                      // R17
      active_p2p_gain_cut <= cfg3_q[`RXDC_GAIN_CUT_BIT];                  // R18
      gain_init           <= rg_go;                                       // R16
      if (rg_go)
        gain_red_load <= cfg4_q; // R15
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `RXDC_OFS_RX_CFG2: reg_rdata <= cfg2_q;
        `RXDC_OFS_RX_CFG3: reg_rdata <= cfg3_q;
        `RXDC_OFS_RX_CFG4: reg_rdata <= cfg4_q;
        `RXDC_OFS_STATUS:  reg_rdata <= {4'h0, busy, squelch_active, mask_q, rx_on_g};
        `RXDC_OFS_ADC_OUT: reg_rdata <= adc_out_q;
        default:           reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ********************
  // Checks
  // ********************
  chk_mask_drops_gate: assert property (@(posedge clk) disable iff (rst) // R1
    mask_go && !unmask_go |=> !rx_on_g && !framing_en)
    else $error("Mask did not drop gate");

  chk_timer_masks: assert property (@(posedge clk) disable iff (rst) // R2
    tmr_mask_eff && !unmask_go |=> !rx_on_g)
    else $error("Timer mask ignored");

  chk_unmask_raises: assert property (@(posedge clk) disable iff (rst) // R3
    unmask_go |=> rx_on_g && framing_en)
    else $error("Unmask did not raise gate");

  chk_unmask_timer_clr: assert property (@(posedge clk) disable iff (rst) // R4
    unmask_go && mask_timer_run |=> mask_timer_clr)
    else $error("Timer not reset on unmask");

  chk_rx_en_gate: assert property (@(posedge clk) disable iff (rst) // R5
    cmd_valid && !rx_en && (cmd_code == rxdc_pkg::RXDC_CMD_MASK_RX
    || cmd_code == rxdc_pkg::RXDC_CMD_UNMASK_RX) |=> mask_q == $past(mask_q))
    else $error("Mask taken while receiver off");

  chk_meas_bound: assert property (@(posedge clk) disable iff (rst) // R8
    meas_go |=> ##[1:MEAS_CYC] state_q == rxdc_pkg::RXDC_ST_IDLE)
    else $error("Measure overran");

  chk_meas_irq: assert property (@(posedge clk) disable iff (rst) // R10
    state_q == rxdc_pkg::RXDC_ST_MEAS && meas_done |=> cmd_done_irq)
    else $error("No termination event");

  chk_meas_no_chain: assert property (@(posedge clk) disable iff (rst) // R10
    state_q == rxdc_pkg::RXDC_ST_MEAS |-> !chain_ok)
    else $error("Chaining open during measure");

  chk_squelch_gate: assert property (@(posedge clk) disable iff (rst) // R13
    !squelch_active && (rx_on_g || !tx_en) |=> !squelch_active)
    else $error("Squelch ran with gate high");

  chk_rg_abort: assert property (@(posedge clk) disable iff (rst) // R15
    rg_go |=> !squelch_active && gain_red_load == $past(cfg4_q))
    else $error("Reset gain failed");

  chk_mask_holds: assert property (@(posedge clk) disable iff (rst) // R22
    mask_q && !unmask_go |=> mask_q)
    else $error("Mask lost");

endmodule

`default_nettype wire

// ### verif/rxdc_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************
// Command issuer
// ****************
module rxdc_mcu_model
(
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  // Command port
  output logic      [2:0] cmd_code,
  output logic            cmd_valid
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cmd_code = 3'h0;
    cmd_valid = 1'b0;
  end

  // Released lines show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // Returns just after outputs of the taking edge settle
  task automatic cmd(input logic [2:0] c);
    @(posedge clk);
    cmd_code <= c;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    #1;
  endtask
endmodule

`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int MC = 8;
  localparam int SC = 20;
  logic       clk, rst, osc_en, osc_stable, rx_en, tx_en, tmr_run, adc_valid;
  logic [7:0] adc_data, reg_addr, reg_wdata, reg_rdata, gain_red_load, v, g;
  logic [2:0] cmd_code, lowpass_sel, zero_sel;
  logic       reg_wr, reg_rd, cmd_valid, cmd_done_irq, chain_ok, mask_timer_clr;
  logic       rx_on, framing_en, tx_force, amp_det_en, adc_abs_sel;
  logic       squelch_active, gain_init, stage_clip_en, active_p2p_gain_cut;
  int         n_mismatch, check_count, n, n_irq, seed_ret;
  logic [7:0] c2e, c4e, adce, a;
  logic [2:0] rc;
  logic       msk_e, ovr_e;

  rxdc_unit #(.MEAS_CYC(MC), .SQ_CYC(SC)) dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
    .osc_en(osc_en), .osc_stable(osc_stable), .rx_en(rx_en), .tx_en(tx_en),
    .mask_timer_run(tmr_run), .adc_data(adc_data), .adc_valid(adc_valid),
    .cmd_done_irq(cmd_done_irq), .chain_ok(chain_ok), .mask_timer_clr(mask_timer_clr),
    .rx_on(rx_on), .framing_en(framing_en), .tx_force(tx_force),
    .amp_det_en(amp_det_en), .adc_abs_sel(adc_abs_sel),
    .squelch_active(squelch_active), .gain_init(gain_init),
    .gain_red_load(gain_red_load), .lowpass_sel(lowpass_sel), .zero_sel(zero_sel),
    .stage_clip_en(stage_clip_en), .active_p2p_gain_cut(active_p2p_gain_cut));

  rxdc_mcu_model mcu (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_code(cmd_code),
    .cmd_valid(cmd_valid));

  initial clk = 1'b0;
  always #20 clk = ~clk;
  always @(posedge clk) if (cmd_done_irq === 1'b1) n_irq++;

  // ****************
  // Checking helpers
  // ****************
  function automatic logic [7:0] cfg3_exp(input logic [7:0] d);
    return d & 8'h03;
  endfunction

  function automatic logic gate_exp(input logic en);
    return en & ~msk_e & ~(tmr_run & ~ovr_e);
  endfunction

  function automatic logic [7:0] reg_exp(input logic [7:0] ad);
    case (ad)
      8'h0b:   return c2e;
      8'h0c:   return cfg3_exp(c2e);
      8'h0d:   return c4e;
      8'h40:   return {6'h00, msk_e, gate_exp(rx_en)};
      8'h41:   return adce;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wait_irq;
    n = 0;
    while (cmd_done_irq !== 1'b1 && n < MC + 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  initial
  begin
    #(40 * 3000);
    n_mismatch++;
    tally_and_finish;
  end

  // ****************
  // Test sequence
  // ****************
  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    n_irq = 0;
    rst = 1'b1;
    {osc_en, osc_stable, rx_en, tx_en, tmr_run, adc_valid} = 6'h00;
    adc_data = 8'h00;
    seed_ret = $urandom(32'h919a);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("chain_rst", 8'h01, chain_ok);
    chk("rx_on_rst", 8'h00, rx_on);
    mcu.rd(8'h0c, v);
    chk("cfg3_rst", 8'h00, v);
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      mcu.wr(8'h0b, v);
      mcu.wr(8'h0c, v);
      c2e = v;
      @(posedge clk);
      #1;
      chk("lowpass", 8'(v[5:3]), 8'(lowpass_sel));
      chk("zero", 8'(v[2:0]), 8'(zero_sel));
      chk("clip", 8'(v[1]), 8'(stage_clip_en));
      chk("gain_cut", 8'(v[0]), 8'(active_p2p_gain_cut));
      mcu.rd(8'h0c, g);
      chk("cfg3_rd", cfg3_exp(v), g);
    end
    mcu.rd(8'h20, v);
    chk("unmapped", 8'h00, v);
    // Mask and unmask
    rx_en <= 1'b1;
    mcu.cmd(3'h2);
    chk("unmask_on", 8'h01, rx_on);
    chk("unmask_frm", 8'h01, framing_en);
    chk("tclr_idle", 8'h00, mask_timer_clr);
    mcu.cmd(3'h1);
    chk("mask_on", 8'h00, rx_on);
    chk("mask_frm", 8'h00, framing_en);
    chk("mask_chain", 8'h01, chain_ok);
    @(posedge clk);
    rx_en <= 1'b0;
    mcu.cmd(3'h2);
    rx_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("unmask_off", 8'h00, rx_on);
    mcu.cmd(3'h2);
    @(posedge clk);
    tmr_run <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("timer_or", 8'h00, rx_on);
    mcu.cmd(3'h2);
    chk("timer_unmask", 8'h01, rx_on);
    chk("timer_clr", 8'h01, mask_timer_clr);
    @(posedge clk);
    tmr_run <= 1'b0;
    #1;
    chk("timer_hold", 8'h01, rx_on);
    chk("mask_irq", 8'h00, 8'(n_irq));
    // Measure amplitude
    osc_en <= 1'b1;
    mcu.cmd(3'h3);
    chk("meas_nostab", 8'h00, tx_force);
    wait_irq;
    chk("meas_noirq", 8'h00, 8'(n_irq));
    osc_stable <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      mcu.cmd(3'h3);
      chk("meas_tx", 8'h01, tx_force);
      chk("meas_det", 8'h01, amp_det_en);
      chk("meas_abs", 8'h01, adc_abs_sel);
      chk("meas_chain", 8'h00, chain_ok);
      v = 8'($urandom);
      if (k == 0)
      begin
        @(posedge clk);
        adc_data <= v;
        adce = v;
        adc_valid <= 1'b1;
        @(posedge clk);
        adc_valid <= 1'b0;
        adc_data <= ~v;
        #1;
      end
      wait_irq;
      chk("meas_time", 8'h01, 8'(n <= MC));
      chk("meas_irq", 8'h01, cmd_done_irq);
      @(posedge clk);
      #1;
      chk("meas_end", 8'h00, tx_force);
      chk("irq_pulse", 8'h00, cmd_done_irq);
      if (k == 0)
      begin
        mcu.rd(8'h41, g);
        chk("adc_store", v, g);
      end
    end
    // Squelch and reset gain
    n_irq = 0;
    tx_en <= 1'b1;
    mcu.cmd(3'h4);
    chk("sq_rx_on", 8'h00, squelch_active);
    mcu.cmd(3'h1);
    tx_en <= 1'b0;
    mcu.cmd(3'h4);
    chk("sq_no_tx", 8'h00, squelch_active);
    tx_en <= 1'b1;
    mcu.cmd(3'h4);
    chk("sq_run", 8'h01, squelch_active);
    chk("sq_chain", 8'h00, chain_ok);
    n = 0;
    while (squelch_active === 1'b1 && n < SC + 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("sq_time", 8'h01, 8'(n <= SC));
    chk("sq_irq", 8'h00, 8'(n_irq));
    g = 8'($urandom);
    mcu.wr(8'h0d, g);
    c4e = g;
    mcu.cmd(3'h4);
    mcu.cmd(3'h5);
    chk("rg_abort", 8'h00, squelch_active);
    chk("rg_init", 8'h01, gain_init);
    chk("rg_load", g, gain_red_load);
    chk("rg_chain", 8'h01, chain_ok);
    osc_en <= 1'b0;
    mcu.cmd(3'h5);
    chk("rg_noosc", 8'h00, gain_init);
    chk("rg_irq", 8'h00, 8'(n_irq));
    // Random levels, commands and reads
    msk_e = 1'b1;
    ovr_e = 1'b0;
    for (int r = 0; r < 40; r++)
    begin
      @(posedge clk);
      {osc_en, osc_stable, rx_en, tx_en, tmr_run, adc_valid} <= 6'($urandom);
      adc_data <= 8'($urandom);
      rc = 3'($urandom % 6);
      if (rc == 3'h3)
        rc = 3'h5;
      if (rc == 3'h4)
        rc = 3'h0;
      mcu.cmd(rc);
      ovr_e = ovr_e & tmr_run;
      if (rx_en && rc == 3'h1)
        msk_e = 1'b1;
      if (rx_en && rc == 3'h2)
      begin
        msk_e = 1'b0;
        ovr_e = tmr_run;
      end
      chk("rnd_rx_on", 8'(gate_exp(rx_en)), 8'(rx_on));
      chk("rnd_framing", 8'(gate_exp(1'b1)), 8'(framing_en));
      chk("rnd_tclr", 8'(rx_en && rc == 3'h2 && tmr_run), 8'(mask_timer_clr));
      chk("rnd_ginit", 8'(rc == 3'h5 && osc_en && osc_stable), 8'(gain_init));
      chk("rnd_gload", c4e, gain_red_load);
      chk("rnd_chain", 8'h01, 8'(chain_ok));
      a = r[0] ? 8'h40 : 8'($urandom);
      mcu.rd(a, v);
      chk("rnd_reg", reg_exp(a), v);
    end
    chk("rnd_irq", 8'h00, 8'(n_irq));
    tally_and_finish;
  end
endmodule

`default_nettype wire
